// ==== rtl/balu_core.sv ====
// balu_core: byte execution datapath for five single-word instructions
// assumes: decoder supplies fdata for faddr in the same cycle and accepts
// the file write-back port one cycle later
//
// Summary of operation
// - subtract W and borrow from f
// - subtract result to W or file by dest
// - swap nibbles of f, flags untouched
// - swap result to W or file by dest
// - copy W to port direction by operand
// - xor W with literal into W, Z only
// - xor W with f to dest, Z only
// - carry and digit carry mean no borrow
`timescale 1ns/1ns
module balu_core (
	input  wire logic                  mclk,
	input  wire logic                  rstn,
	input  wire balu_pkg::balu_instr_s instr,
	input  wire balu_pkg::balu_flags_s flags_in,
	output balu_pkg::balu_byte_t       wreg_q,
	output balu_pkg::balu_flags_s      flags_q,
	output balu_pkg::balu_fwr_s        fwr_q,
	output balu_pkg::balu_byte_t       port_a_direction,
	output balu_pkg::balu_byte_t       port_b_direction,
	output balu_pkg::balu_byte_t       port_c_direction
);
	import balu_pkg::*;

	balu_byte_t  res;
	balu_flags_s cflg;
	logic        go;
	logic        to_w;
	logic        to_f;

	// ********************************************************
	// compute
	// ********************************************************
	// carry comes in from the shared status so chained subtracts work
	balu_calc u_calc (
		.op   (instr.op),
		.wreg (wreg_q),
		.fval (instr.fdata),
		.lit  (instr.lit),
		.cin  (flags_in.c),
		.res  (res),
		.flg  (cflg)
	);

	assign go   = instr.valid;
	assign to_w = go && ((instr.op == BALU_OP_XORL) ||
		(instr.dest == BALU_DEST_W && (instr.op == BALU_OP_SUBB ||
		instr.op == BALU_OP_SWAP || instr.op == BALU_OP_XORF)));
	assign to_f = go && instr.dest == BALU_DEST_F &&
		(instr.op == BALU_OP_SUBB || instr.op == BALU_OP_SWAP ||
		instr.op == BALU_OP_XORF);

	// ********************************************************
	// working register
	// ********************************************************
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			wreg_q <= BALU_ZERO;
		end else if (to_w) begin
			wreg_q <= res;
		end
	end

	// ********************************************************
	// file write-back
	// ********************************************************
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			fwr_q <= '0;
		end else begin
			fwr_q.we   <= to_f;
			fwr_q.addr <= instr.faddr;
			fwr_q.data <= res;
		end
	end

	// ********************************************************
	// status flags
	// ********************************************************
	// flags mirror the input when untouched so the outside can take them
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			flags_q <= '0;
		end else begin
			flags_q <= flags_in;
			if (go) begin
				unique case (instr.op)
					BALU_OP_SUBB: flags_q <= cflg;
					BALU_OP_XORL,
					BALU_OP_XORF: flags_q.z <= cflg.z;
					default: flags_q <= flags_in;
				endcase
			end
		end
	end

	// ********************************************************
	// port direction registers
	// ********************************************************
	// out-of-range operands load nothing rather than aliasing a port
	// each port owns its register so no variable has two writers
	for (genvar i = 0; i < BALU_NUM_DIR; i++) begin : g_dir
		balu_byte_t dir_q;
		always_ff @(posedge mclk or negedge rstn) begin
			if (!rstn) begin
				dir_q <= BALU_DIR_RST;
			end else if (go && instr.op == BALU_OP_DIRLD &&
				instr.faddr == BALU_SEL_PORT_A + BALU_FA_W'(i)) begin
				dir_q <= wreg_q;
			end
		end
	end

	assign port_a_direction = g_dir[0].dir_q;
	assign port_b_direction = g_dir[1].dir_q;
	assign port_c_direction = g_dir[2].dir_q;

	// ********************************************************
	// checks
	// ********************************************************
	property p_subb_w;
		@(posedge mclk) disable iff (!rstn)
		(go && instr.op == BALU_OP_SUBB && instr.dest == BALU_DEST_W)
		|=> wreg_q == balu_byte_t'($past(instr.fdata) - $past(wreg_q)
			- balu_byte_t'(!$past(flags_in.c)));
	endproperty
	a_subb_w: assert property (p_subb_w) else $error("subtract to w wrong");

	property p_subb_f;
		@(posedge mclk) disable iff (!rstn)
		(go && instr.op == BALU_OP_SUBB && instr.dest == BALU_DEST_F)
		|=> fwr_q.we && $stable(wreg_q);
	endproperty
	a_subb_f: assert property (p_subb_f) else $error("subtract dest wrong");

	property p_swap;
		@(posedge mclk) disable iff (!rstn)
		(go && instr.op == BALU_OP_SWAP)
		|=> fwr_q.data == {$past(instr.fdata[BALU_NIB_LS:0]),
			$past(instr.fdata[BALU_NIB_HI:BALU_NIB_MS])}
			&& flags_q == $past(flags_in);
	endproperty
	a_swap: assert property (p_swap) else $error("swap wrong");

	property p_swap_dest;
		@(posedge mclk) disable iff (!rstn)
		(go && instr.op == BALU_OP_SWAP) |=> fwr_q.we == $past(instr.dest);
	endproperty
	a_swap_dest: assert property (p_swap_dest) else $error("swap dest");

	property p_dirld;
		@(posedge mclk) disable iff (!rstn)
		(go && instr.op == BALU_OP_DIRLD && instr.faddr == BALU_SEL_PORT_B)
		|=> port_b_direction == $past(wreg_q) && !fwr_q.we;
	endproperty
	a_dirld: assert property (p_dirld) else $error("direction load");

	property p_xorl;
		@(posedge mclk) disable iff (!rstn)
		(go && instr.op == BALU_OP_XORL) |=> wreg_q ==
			($past(wreg_q) ^ $past(instr.lit)) && flags_q.c == $past(flags_in.c);
	endproperty
	a_xorl: assert property (p_xorl) else $error("xor literal");

	property p_xorf;
		@(posedge mclk) disable iff (!rstn)
		(go && instr.op == BALU_OP_XORF && instr.dest == BALU_DEST_F)
		|=> fwr_q.data == ($past(wreg_q) ^ $past(instr.fdata))
			&& flags_q.dc == $past(flags_in.dc);
	endproperty
	a_xorf: assert property (p_xorf) else $error("xor file");

	property p_carry;
		@(posedge mclk) disable iff (!rstn)
		(go && instr.op == BALU_OP_SUBB && {1'b0, instr.fdata} <
			{1'b0, wreg_q} + 9'(!flags_in.c)) |=> !flags_q.c;
	endproperty
	a_carry: assert property (p_carry) else $error("borrow carry");

	property p_zero;
		@(posedge mclk) disable iff (!rstn)
		(go && instr.op == BALU_OP_XORF && instr.fdata == wreg_q)
		|=> flags_q.z;
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag");

	property p_dir_a;
		@(posedge mclk) disable iff (!rstn)
		(go && instr.op == BALU_OP_DIRLD &&
			instr.faddr == BALU_SEL_PORT_A)
		|=> port_a_direction == $past(wreg_q) && $stable(port_b_direction);
	endproperty
	a_dir_a: assert property (p_dir_a) else $error("direction a");

	property p_dir_c;
		@(posedge mclk) disable iff (!rstn)
		(go && instr.op == BALU_OP_DIRLD &&
			instr.faddr == BALU_SEL_PORT_C)
		|=> port_c_direction == $past(wreg_q) && $stable(port_a_direction);
	endproperty
	a_dir_c: assert property (p_dir_c) else $error("direction c");

	// operands outside the port range must not alias onto any port
	property p_dir_bad;
		@(posedge mclk) disable iff (!rstn)
		(go && instr.op == BALU_OP_DIRLD &&
			(instr.faddr < BALU_SEL_PORT_A || instr.faddr > BALU_SEL_PORT_C))
		|=> $stable(port_a_direction) && $stable(port_b_direction)
			&& $stable(port_c_direction);
	endproperty
	a_dir_bad: assert property (p_dir_bad) else $error("direction alias");

	property p_idle;
		@(posedge mclk) disable iff (!rstn)
		!go |=> !fwr_q.we && $stable(wreg_q) && flags_q == $past(flags_in);
	endproperty
	a_idle: assert property (p_idle) else $error("idle cycle wrote");

	property p_xorf_w;
		@(posedge mclk) disable iff (!rstn)
		(go && instr.op == BALU_OP_XORF && instr.dest == BALU_DEST_W)
		|=> wreg_q == ($past(wreg_q) ^ $past(instr.fdata)) && !fwr_q.we;
	endproperty
	a_xorf_w: assert property (p_xorf_w) else $error("xor file to w");

	property p_swap_w;
		@(posedge mclk) disable iff (!rstn)
		(go && instr.op == BALU_OP_SWAP && instr.dest == BALU_DEST_W)
		|=> wreg_q == {$past(instr.fdata[BALU_NIB_LS:0]),
			$past(instr.fdata[BALU_NIB_HI:BALU_NIB_MS])};
	endproperty
	a_swap_w: assert property (p_swap_w) else $error("swap to w");

	property p_subb_dc;
		@(posedge mclk) disable iff (!rstn)
		(go && instr.op == BALU_OP_SUBB &&
			{1'b0, instr.fdata[BALU_NIB_LS:0]} >=
			{1'b0, wreg_q[BALU_NIB_LS:0]} + 5'(!flags_in.c))
		|=> flags_q.dc;
	endproperty
	a_subb_dc: assert property (p_subb_dc) else $error("digit carry");

	property p_xorl_z;
		@(posedge mclk) disable iff (!rstn)
		(go && instr.op == BALU_OP_XORL)
		|=> flags_q.z == (wreg_q == BALU_ZERO);
	endproperty
	a_xorl_z: assert property (p_xorl_z) else $error("xor zero flag");
endmodule

// ==== rtl/balu_pkg.sv ====
// balu_pkg: opcodes, carriers and constants for the byte execution datapath
// assumes: the decoder presents one instruction per cycle on balu_instr_s
package balu_pkg;

	// ********************************************************
	// widths and field positions
	// ********************************************************
	localparam int BALU_W      = 8;
	localparam int BALU_NIB_HI = 7;
	localparam int BALU_NIB_MS = 4;
	localparam int BALU_NIB_LS = 3;
	localparam int BALU_FA_W   = 7;
	localparam int BALU_NUM_DIR = 3;

	typedef logic [BALU_W-1:0] balu_byte_t;

	// ********************************************************
	// direction-load operand selectors and reset values
	// ********************************************************
	localparam logic [BALU_FA_W-1:0] BALU_SEL_PORT_A = 7'h05;
	localparam logic [BALU_FA_W-1:0] BALU_SEL_PORT_B = 7'h06;
	localparam logic [BALU_FA_W-1:0] BALU_SEL_PORT_C = 7'h07;
	localparam balu_byte_t BALU_DIR_RST  = 8'hff;
	localparam balu_byte_t BALU_ZERO     = 8'h00;
	localparam logic       BALU_DEST_W   = 1'h0;
	localparam logic       BALU_DEST_F   = 1'h1;

	typedef enum logic [2:0] {
		BALU_OP_NONE,
		BALU_OP_SUBB,
		BALU_OP_SWAP,
		BALU_OP_DIRLD,
		BALU_OP_XORL,
		BALU_OP_XORF
	} balu_op_e;

	typedef struct packed {
		logic                 valid;
		balu_op_e             op;
		logic [BALU_FA_W-1:0] faddr;
		logic                 dest;
		balu_byte_t           lit;
		balu_byte_t           fdata;
	} balu_instr_s;

	typedef struct packed {
		logic c;
		logic dc;
		logic z;
	} balu_flags_s;

	typedef struct packed {
		logic                 we;
		logic [BALU_FA_W-1:0] addr;
		balu_byte_t           data;
	} balu_fwr_s;

endpackage

// ==== rtl/balu_calc.sv ====
// balu_calc: combinational result and flag computation for one instruction
// assumes: operands are stable for the whole cycle; no state held here
`timescale 1ns/1ns
module balu_calc (
	input  wire balu_pkg::balu_op_e    op,
	input  wire balu_pkg::balu_byte_t  wreg,
	input  wire balu_pkg::balu_byte_t  fval,
	input  wire balu_pkg::balu_byte_t  lit,
	input  wire logic                  cin,
	output balu_pkg::balu_byte_t       res,
	output balu_pkg::balu_flags_s      flg
);
	import balu_pkg::*;

	logic [BALU_W:0]      diff;
	logic [BALU_NIB_MS:0] ndiff;
	logic                 bin;

	// borrow in is the inverted carry; carry out is the inverted borrow
	assign bin   = ~cin;
	assign diff  = {1'b0, fval} - {1'b0, wreg} - {{BALU_W{1'b0}}, bin};
	assign ndiff = {1'b0, fval[BALU_NIB_LS:0]} - {1'b0, wreg[BALU_NIB_LS:0]}
		- {{BALU_NIB_MS{1'b0}}, bin};

	always_comb begin
		res = BALU_ZERO;
		unique case (op)
			BALU_OP_SUBB: res = diff[BALU_W-1:0];
			BALU_OP_SWAP: res = {fval[BALU_NIB_LS:0],
				fval[BALU_NIB_HI:BALU_NIB_MS]};
			BALU_OP_XORL: res = wreg ^ lit;
			BALU_OP_XORF: res = wreg ^ fval;
			default:      res = wreg;
		endcase
	end

	always_comb begin
		flg.c  = ~diff[BALU_W];
		flg.dc = ~ndiff[BALU_NIB_MS];
		flg.z  = (res == BALU_ZERO);
	end
endmodule

// ==== test/balu_mem_model.sv ====
// balu_mem_model: decoder and file register stand-in for balu_core
// assumes: file writes land one edge after fwr_q.we is seen
`timescale 1ns/1ns
module balu_mem_model (
	input  wire logic                  mclk,
	input  wire balu_pkg::balu_instr_s cmd,
	input  wire balu_pkg::balu_fwr_s   fwr,
	input  wire balu_pkg::balu_fwr_s   pre,
	input  wire balu_pkg::balu_flags_s flg,
	output balu_pkg::balu_instr_s      instr,
	output balu_pkg::balu_flags_s      flags_in
);
	import balu_pkg::*;
	// ****
	// file read is same cycle; flags loop back for chaining
	// ****
	balu_byte_t mem [128];
	always_comb begin
		instr = cmd;
		instr.fdata = mem[cmd.faddr];
		flags_in = flg;
	end
	always_ff @(posedge mclk) begin
		if (fwr.we) begin
			mem[fwr.addr] <= fwr.data;
		end else if (pre.we) begin
			mem[pre.addr] <= pre.data;
		end
	end
endmodule

// ==== test/testbench.sv ====
// testbench: directed scenarios for balu_core
// assumes: latency one, flags fed back through balu_mem_model
`timescale 1ns/1ns
module testbench;
	import balu_pkg::*;
	logic        mclk;
	logic        rstn;
	balu_instr_s cmd;
	balu_instr_s instr;
	balu_flags_s flags_in;
	balu_byte_t  wreg_q;
	balu_flags_s flags_q;
	balu_fwr_s   fwr_q;
	balu_fwr_s   pre;
	balu_byte_t  dir_a;
	balu_byte_t  dir_b;
	balu_byte_t  dir_c;
	int          num_errors;
	int          checks;
	balu_byte_t  ew;
	balu_flags_s ef;
	balu_core u_dut (.mclk(mclk), .rstn(rstn), .instr(instr),
		.flags_in(flags_in), .wreg_q(wreg_q), .flags_q(flags_q),
		.fwr_q(fwr_q), .port_a_direction(dir_a),
		.port_b_direction(dir_b), .port_c_direction(dir_c));
	balu_mem_model u_mem (.mclk(mclk), .cmd(cmd), .fwr(fwr_q),
		.pre(pre), .flg(flags_q), .instr(instr), .flags_in(flags_in));
	// ****
	// shared tasks
	// ****
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic run(input balu_op_e op, input logic [6:0] fa,
		input logic d, input balu_byte_t k);
		@(posedge mclk);
		#1 cmd = '{1'b1, op, fa, d, k, 8'h00};
		@(posedge mclk);
		#1 cmd.valid = 1'b0;
	endtask
	// file preload goes through the model's write port, never by poking
	task automatic poke(input logic [6:0] fa, input balu_byte_t v);
		@(posedge mclk);
		#1 pre = '{1'b1, fa, v};
		@(posedge mclk);
		#1 pre.we = 1'b0;
	endtask
	task automatic end_of_test();
		if (num_errors == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// ****
	// scenarios
	// ****
	task automatic t_dir();
		balu_byte_t ed [3] = '{8'hff, 8'hff, 8'hff};
		for (int i = 4; i < 8; i++) begin
			run(BALU_OP_XORL, 7'h00, 1'b0, ew ^ 8'(8'h30 + i));
			ew = 8'(8'h30 + i);
			ef.z = 1'b0;
			run(BALU_OP_DIRLD, 7'(i), 1'b0, 8'h00);
			if (i > 4) ed[i-5] = ew;
			check(16'(dir_a), 16'(ed[0]));
			check(16'(dir_b), 16'(ed[1]));
			check(16'(dir_c), 16'(ed[2]));
			check(16'(flags_q), 16'(ef));
		end
	endtask
	task automatic t_xorl();
		balu_byte_t k [3] = '{8'h5a, 8'h6d, 8'hc3};
		for (int i = 0; i < 3; i++) begin
			run(BALU_OP_XORL, 7'h11, 1'b1, k[i]);
			ew ^= k[i];
			ef.z = (ew == 8'h00);
			check(16'(wreg_q), 16'(ew));
			check(16'(flags_q), 16'(ef));
			check(16'(fwr_q.we), 16'h0000);
		end
	endtask
	task automatic t_xorf();
		poke(7'h03, 8'h3c);
		run(BALU_OP_XORF, 7'h03, 1'b0, 8'h00);
		ew ^= 8'h3c;
		ef.z = (ew == 8'h00);
		check(16'(wreg_q), 16'(ew));
		check(16'(flags_q), 16'(ef));
		check(16'(fwr_q.we), 16'h0000);
		poke(7'h04, ew);
		run(BALU_OP_XORF, 7'h04, 1'b1, 8'h00);
		ef.z = 1'b1;
		check(16'(wreg_q), 16'(ew));
		check(16'(fwr_q), {1'b1, 7'h04, 8'h00});
		check(16'(flags_q), 16'(ef));
	endtask
	task automatic t_swap();
		poke(7'h09, 8'h1e);
		poke(7'h08, 8'ha7);
		run(BALU_OP_SWAP, 7'h09, 1'b1, 8'h00);
		check(16'(fwr_q), {1'b1, 7'h09, 8'he1});
		check(16'(flags_q), 16'(ef));
		run(BALU_OP_SWAP, 7'h08, 1'b0, 8'h00);
		check(16'(wreg_q), 16'h007a);
		check(16'(fwr_q.we), 16'h0000);
		check(16'(flags_q), 16'(ef));
		ew = 8'h7a;
	endtask
	// borrow chain carries c from one subtract into the next
	task automatic t_subb();
		balu_byte_t tw [4] = '{8'h01, 8'h0f, 8'h20, 8'h10};
		balu_byte_t tf [4] = '{8'h00, 8'h10, 8'h20, 8'hff};
		logic [8:0] r;
		logic [4:0] n;
		for (int i = 0; i < 4; i++) begin
			poke(7'(16 + i), tf[i]);
			run(BALU_OP_XORL, 7'h00, 1'b0, ew ^ tw[i]);
			r = {1'b0, tf[i]} - {1'b0, tw[i]} - 9'(!ef.c);
			n = {1'b0, tf[i][3:0]} - {1'b0, tw[i][3:0]} - 5'(!ef.c);
			ew = i[0] ? tw[i] : r[7:0];
			ef = '{~r[8], ~n[4], r[7:0] == 8'h00};
			run(BALU_OP_SUBB, 7'(16 + i), i[0], 8'h00);
			check(16'(wreg_q), 16'(ew));
			check(16'(flags_q), 16'(ef));
			check(16'(fwr_q.we), 16'(i[0]));
			if (i[0]) begin
				check(16'(fwr_q), {1'b1, 7'(16 + i), r[7:0]});
			end
		end
	endtask
	// mid-run reset: wreg_q, flags_q, fwr_q and dir_c go to reset values at once (dir_c to ff), then work resumes
	task automatic t_reset();
		@(posedge mclk);
		#1 rstn = 1'b0;
		#1;
		check(16'(wreg_q), 16'h0000);
		check(16'(flags_q), 16'h0000);
		check(16'(fwr_q), 16'h0000);
		check(16'(dir_c), 16'h00ff);
		repeat (3) @(posedge mclk);
		#1 rstn = 1'b1;
		ew = 8'h00;
		ef = '0;
		run(BALU_OP_NONE, 7'h05, 1'b1, 8'h00);
		check(16'(wreg_q), 16'h0000);
		check(16'(fwr_q.we), 16'h0000);
		check(16'(dir_a), 16'h00ff);
		run(BALU_OP_XORL, 7'h00, 1'b0, 8'h96);
		check(16'(wreg_q), 16'h0096);
		check(16'(flags_q), 16'(ef));
	endtask
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	initial begin
		num_errors = 0;
		checks = 0;
		rstn = 1'b0;
		cmd = '0;
		ew = 8'h00;
		ef = '0;
		pre = '0;
		repeat (3) @(posedge mclk);
		#1 rstn = 1'b1;
		t_dir();
		t_xorl();
		t_xorf();
		t_swap();
		t_subb();
		t_reset();
		end_of_test();
	end
endmodule
